// ### hdl/mfe_defs.svh
`ifndef MFE_DEFS_SVH
`define MFE_DEFS_SVH
// Octet and symbol constants
`define MFE_PRE_OCTET     8'h55
`define MFE_SFD_OCTET     8'hd5
`define MFE_PRE_COUNT     4'h7
`define MFE_ADDR_OCTETS   12'h00c
`define MFE_TL_OCTETS     12'h002
`define MFE_MIN_DATA      12'h02e
`define MFE_MAX_DATA      12'h5dc
`define MFE_MIN_FRAME     12'h040
`define MFE_MAX_FRAME     12'h5ee
`define MFE_PAD_OCTET     8'h00
`define MFE_CRC_POLY      32'h04c11db7
`define MFE_CRC_INIT      32'hffffffff
`define MFE_CRC_RESIDUE   32'hc704dd7b
// Stream delimiter code groups (5 bit)
`define MFE_SYM_J         5'h18
`define MFE_SYM_K         5'h11
`define MFE_SYM_T         5'h0d
`define MFE_SYM_R         5'h07
// Data code groups, the group for nibble n sits at bits 5n+4:5n
`define MFE_4B5B_TABLE    80'hef37a_bda72_7b96a_ad13e
`endif

// ### hdl/mfe_pkg.sv
package mfe_pkg;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       last;
   } mfe_octet_t;
   typedef struct packed {
      logic       valid;
      logic [4:0] sym;
   } mfe_sym_t;
   typedef enum logic [6:0] {
      TX_IDLE = 7'h01,
      TX_PRE  = 7'h02,
      TX_SFD  = 7'h04,
      TX_BODY = 7'h08,
      TX_PAD  = 7'h10,
      TX_FCS  = 7'h20,
      TX_END  = 7'h40
   } mfe_tx_st_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h1,
      RX_PRE  = 3'h2,
      RX_BODY = 3'h4
   } mfe_rx_st_t;
endpackage

// ### hdl/mfe_top.sv
// Purpose: Ethernet frame encapsulation (one octet per enable) and decapsulation (one octet per valid input).
// Assumes: host octets arrive on tx_in without gaps once a frame starts; symbol
//          mode carries each octet as two 5-bit code groups, low nibble first.
// Notes: Receive reports length/type, CRC result and size error at frame end.
`include "mfe_defs.svh"
module mfe_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Mode and pacing
   input wire logic sym_mode_in,
   input wire logic pad_dis_in,
   input wire logic octet_en_in,
   // Host transmit octets
   input wire mfe_pkg::mfe_octet_t tx_in,
   output logic tx_ready_out,
   // Transmit to physical layer
   output mfe_pkg::mfe_octet_t txo_out,
   output mfe_pkg::mfe_sym_t tx_sym_out,
   // Receive from physical layer
   input wire mfe_pkg::mfe_octet_t rxi_in,
   input wire mfe_pkg::mfe_sym_t rx_sym_in,
   // Receive to host
   output mfe_pkg::mfe_octet_t rx_out,
   output logic rx_done_out,
   output logic rx_crc_err_out,
   output logic rx_size_err_out,
   output logic rx_is_type_out,
   output logic [15:0] rx_tl_out
);
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      logic fb;
      r = c;
      for (int i = 0; i < 8; i++) begin
         fb = r[31] ^ d[i];
         r = {r[30:0], 1'b0} ^ (fb ? `MFE_CRC_POLY : 32'h0);
      end
      return r;
   endfunction

   function automatic logic [7:0] fcs_octet(input logic [31:0] c, input logic [1:0] k);
      logic [7:0] o;
      logic [31:0] n;
      n = ~c;
      for (int i = 0; i < 8; i++) begin
         o[i] = n[31 - 8 * k - i];
      end
      return o;
   endfunction

   function automatic logic [4:0] enc45(input logic [3:0] n);
      logic [79:0] t;
      t = `MFE_4B5B_TABLE;
      return t[5 * int'(n) +: 5];
   endfunction

   function automatic logic [3:0] dec54(input logic [4:0] s);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (enc45(4'(i)) == s) begin
            n = 4'(i);
         end
      end
      return n;
   endfunction

   typedef struct packed {
      // Symbol inputs come from the line domain: two stages before any use
      logic [5:0]  rs1;
      logic [5:0]  rs2;
      mfe_pkg::mfe_tx_st_t tst;
      logic [3:0]  pcnt;
      logic [11:0] bcnt;
      logic [1:0]  fcnt;
      logic [31:0] tcrc;
      logic        half;
      logic [7:0]  hold;
      logic        tready;
      mfe_pkg::mfe_octet_t txo;
      mfe_pkg::mfe_sym_t   tsym;
      mfe_pkg::mfe_rx_st_t rst;
      logic        shalf;
      logic [3:0]  slow;
      logic        sact;
      mfe_pkg::mfe_octet_t sdec;
      logic [11:0] rcnt;
      logic [31:0] rcrc;
      logic [15:0] tl;
      mfe_pkg::mfe_octet_t rxo;
      logic        done;
      logic        cerr;
      logic        serr;
      logic        istype;
   } mfe_state_t;

   mfe_state_t s_q, s_d;
   mfe_pkg::mfe_octet_t rin;
   logic [7:0] tx_oct;
   logic tx_emit;

   always_comb begin
      s_d = s_q;
      tx_oct = 8'h00;
      tx_emit = 1'b0;
      s_d.done = 1'b0;
      s_d.rxo.valid = 1'b0;
      s_d.sdec.valid = 1'b0;
      s_d.txo.valid = 1'b0;
      s_d.tsym.valid = 1'b0;
      s_d.rs1 = {rx_sym_in.valid, rx_sym_in.sym};
      s_d.rs2 = s_q.rs1;
      // Transmit, one field octet per enable
      if (octet_en_in) begin
         unique case (s_q.tst)
            mfe_pkg::TX_IDLE: begin
               if (tx_in.valid) begin
                  s_d.tst = mfe_pkg::TX_PRE;
                  s_d.pcnt = 4'h1;
                  s_d.tcrc = `MFE_CRC_INIT;
                  s_d.bcnt = 12'h000;
                  tx_oct = `MFE_PRE_OCTET;
                  tx_emit = 1'b1;
                  s_d.half = 1'b0;
               end
            end
            mfe_pkg::TX_PRE: begin
               tx_oct = `MFE_PRE_OCTET;
               tx_emit = 1'b1;
               s_d.pcnt = s_q.pcnt + 4'h1;
               if (s_q.pcnt == `MFE_PRE_COUNT - 4'h1) begin
                  s_d.tst = mfe_pkg::TX_SFD;
               end
            end
            mfe_pkg::TX_SFD: begin
               tx_oct = `MFE_SFD_OCTET;
               tx_emit = 1'b1;
               s_d.tst = mfe_pkg::TX_BODY;
            end
            mfe_pkg::TX_BODY: begin
               // Addresses, type/length (high octet first) and data pass as given
               tx_oct = tx_in.data;
               tx_emit = 1'b1;
               s_d.tcrc = crc_step(s_q.tcrc, tx_in.data);
               s_d.bcnt = s_q.bcnt + 12'h001;
               if (tx_in.last) begin
                  if (!pad_dis_in && s_q.bcnt + 12'h001 <
                      `MFE_ADDR_OCTETS + `MFE_TL_OCTETS + `MFE_MIN_DATA) begin
                     s_d.tst = mfe_pkg::TX_PAD;
                  end else begin
                     s_d.tst = mfe_pkg::TX_FCS;
                  end
                  s_d.fcnt = 2'h0;
               end
            end
            mfe_pkg::TX_PAD: begin
               tx_oct = `MFE_PAD_OCTET;
               tx_emit = 1'b1;
               s_d.tcrc = crc_step(s_q.tcrc, `MFE_PAD_OCTET);
               s_d.bcnt = s_q.bcnt + 12'h001;
               if (s_q.bcnt + 12'h001 == `MFE_ADDR_OCTETS + `MFE_TL_OCTETS + `MFE_MIN_DATA) begin
                  s_d.tst = mfe_pkg::TX_FCS;
               end
            end
            mfe_pkg::TX_FCS: begin
               tx_oct = fcs_octet(s_q.tcrc, s_q.fcnt);
               tx_emit = 1'b1;
               s_d.fcnt = s_q.fcnt + 2'h1;
               if (s_q.fcnt == 2'h3) begin
                  s_d.tst = sym_mode_in ? mfe_pkg::TX_END : mfe_pkg::TX_IDLE;
               end
            end
            mfe_pkg::TX_END: begin
               s_d.tst = mfe_pkg::TX_IDLE;
            end
         endcase
      end
      s_d.tready = octet_en_in && s_q.tst == mfe_pkg::TX_BODY;
      if (tx_emit) begin
         s_d.txo.valid = 1'b1;
         s_d.txo.data = tx_oct;
         s_d.txo.last = s_q.tst == mfe_pkg::TX_FCS && s_q.fcnt == 2'h3;
         s_d.hold = tx_oct;
         s_d.half = 1'b0;
      end
      // Symbol path: each octet becomes two code groups on two consecutive clock cycles
      if (sym_mode_in) begin
         s_d.tsym.valid = tx_emit || s_q.half || (octet_en_in && s_q.tst == mfe_pkg::TX_END);
         if (tx_emit) begin
            if (s_q.tst == mfe_pkg::TX_IDLE) begin
               s_d.tsym.sym = `MFE_SYM_J;
            end else begin
               s_d.tsym.sym = enc45(tx_oct[3:0]);
            end
            s_d.half = 1'b1;
         end else if (s_q.half) begin
            if (s_q.tst == mfe_pkg::TX_PRE && s_q.pcnt == 4'h1) begin
               s_d.tsym.sym = `MFE_SYM_K;
            end else begin
               s_d.tsym.sym = enc45(s_q.hold[7:4]);
            end
            s_d.half = 1'b0;
         end else if (octet_en_in && s_q.tst == mfe_pkg::TX_END) begin
            s_d.tsym.sym = `MFE_SYM_T;
            s_d.half = 1'b1;
            s_d.hold = 8'hff;
         end
         if (!tx_emit && s_q.half && s_q.hold == 8'hff && s_q.tst == mfe_pkg::TX_IDLE) begin
            s_d.tsym.sym = `MFE_SYM_R;
         end
      end
      // Receive symbol decapsulation
      if (s_q.rs2[5]) begin
         if (s_q.rs2[4:0] == `MFE_SYM_J) begin
            s_d.sact = 1'b1;
            s_d.shalf = 1'b1;
         end else if (s_q.rs2[4:0] == `MFE_SYM_K && s_q.shalf && s_q.sact) begin
            s_d.sdec.valid = 1'b1;
            s_d.sdec.data = `MFE_PRE_OCTET;
            // A stale end mark from the last frame would block the next start
            s_d.sdec.last = 1'b0;
            s_d.shalf = 1'b0;
         end else if (s_q.rs2[4:0] == `MFE_SYM_T) begin
            s_d.sact = 1'b0;
            s_d.sdec.valid = s_q.sact;
            s_d.sdec.last = 1'b1;
            s_d.shalf = 1'b0;
         end else if (s_q.sact) begin
            if (!s_q.shalf) begin
               s_d.slow = dec54(s_q.rs2[4:0]);
               s_d.shalf = 1'b1;
            end else begin
               s_d.sdec.valid = 1'b1;
               s_d.sdec.data = {dec54(s_q.rs2[4:0]), s_q.slow};
               s_d.sdec.last = 1'b0;
               s_d.shalf = 1'b0;
            end
         end
      end
      rin = sym_mode_in ? s_q.sdec : rxi_in;
      // Receive framing and check
      unique case (s_q.rst)
         mfe_pkg::RX_IDLE: begin
            if (rin.valid && rin.data == `MFE_PRE_OCTET && !rin.last) begin
               s_d.rst = mfe_pkg::RX_PRE;
            end
         end
         mfe_pkg::RX_PRE: begin
            if (rin.valid) begin
               if (rin.data == `MFE_SFD_OCTET) begin
                  s_d.rst = mfe_pkg::RX_BODY;
                  s_d.rcnt = 12'h000;
                  s_d.rcrc = `MFE_CRC_INIT;
               end else if (rin.data != `MFE_PRE_OCTET || rin.last) begin
                  s_d.rst = mfe_pkg::RX_IDLE;
               end
            end
         end
         mfe_pkg::RX_BODY: begin
            if (rin.valid && !(sym_mode_in && rin.last)) begin
               s_d.rxo = rin;
               s_d.rcrc = crc_step(s_q.rcrc, rin.data);
               if (s_q.rcnt != 12'hfff) begin
                  s_d.rcnt = s_q.rcnt + 12'h001;
               end
               if (s_q.rcnt == `MFE_ADDR_OCTETS) begin
                  s_d.tl[15:8] = rin.data;
               end
               if (s_q.rcnt == `MFE_ADDR_OCTETS + 12'h001) begin
                  s_d.tl[7:0] = rin.data;
               end
            end
            if (rin.valid && rin.last) begin
               s_d.rst = mfe_pkg::RX_IDLE;
               s_d.done = 1'b1;
               s_d.rxo.valid = !sym_mode_in;
               s_d.rxo.last = 1'b1;
               // Residue check covers the FCS octets too
               s_d.cerr = (sym_mode_in ? s_q.rcrc : crc_step(s_q.rcrc, rin.data))
                          != `MFE_CRC_RESIDUE;
               s_d.serr = (s_d.rcnt < `MFE_MIN_FRAME) || (s_d.rcnt > `MFE_MAX_FRAME);
               s_d.istype = s_d.tl > {4'h0, `MFE_MAX_DATA};
            end
         end
         default: s_d.rst = mfe_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q <= '0;
         s_q.tst <= mfe_pkg::TX_IDLE;
         s_q.rst <= mfe_pkg::RX_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign tx_ready_out = s_q.tready;
   assign txo_out = s_q.txo;
   assign tx_sym_out = s_q.tsym;
   assign rx_out = s_q.rxo;
   assign rx_done_out = s_q.done;
   assign rx_crc_err_out = s_q.cerr;
   assign rx_size_err_out = s_q.serr;
   assign rx_is_type_out = s_q.istype;
   assign rx_tl_out = s_q.tl;

   AST_PRE_TO_SFD: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.tst == mfe_pkg::TX_PRE && octet_en_in && s_q.pcnt == 4'h6 |=> s_q.tst == mfe_pkg::TX_SFD)
      else $error("preamble length wrong");
   AST_SFD_VALUE: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.tst == mfe_pkg::TX_SFD && octet_en_in |=> txo_out.valid && txo_out.data == 8'hd5)
      else $error("delimiter octet wrong");
   AST_PAD_MIN: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.tst == mfe_pkg::TX_PAD && s_d.tst == mfe_pkg::TX_FCS |-> s_d.bcnt == 12'h03c)
      else $error("padding stopped at wrong count");
   AST_FCS_FOUR: assert property (@(posedge clk_in) disable iff (!rstn_in)
      $rose(s_q.tst == mfe_pkg::TX_FCS) |-> s_q.fcnt == 2'h0)
      else $error("fcs count not reset");
   AST_JK_FIRST: assert property (@(posedge clk_in) disable iff (!rstn_in)
      sym_mode_in && s_q.tst == mfe_pkg::TX_IDLE && octet_en_in && tx_in.valid
      |=> tx_sym_out.valid && tx_sym_out.sym == 5'h18)
      else $error("stream did not open with J");
   AST_T_AFTER: assert property (@(posedge clk_in) disable iff (!rstn_in)
      sym_mode_in && s_q.tst == mfe_pkg::TX_END && octet_en_in
      |=> tx_sym_out.valid && tx_sym_out.sym == 5'h0d)
      else $error("stream did not close with T");
   AST_TYPE_SPLIT: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rx_done_out |-> rx_is_type_out == (rx_tl_out > 16'h05dc))
      else $error("type/length split wrong");
   AST_SIZE_FLAG: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rx_done_out && s_q.rcnt >= 12'h040 && s_q.rcnt <= 12'h5ee |-> !rx_size_err_out)
      else $error("size error on legal frame");
endmodule

// ### tb/mfe_phy_model.sv
// Purpose: Physical layer stand-in that loops the transmit streams back to receive.
// Assumes: one octet or symbol per valid cycle, same clock as the MAC side.
// Notes: idle lines toggle so stale data can never pass for a live octet.
module mfe_phy_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Scenario control
   input wire logic corrupt_in,
   // From the MAC transmit side
   input wire mfe_pkg::mfe_octet_t txo_in,
   input wire mfe_pkg::mfe_sym_t tx_sym_in,
   // Toward the MAC receive side
   output mfe_pkg::mfe_octet_t rxi_out,
   output mfe_pkg::mfe_sym_t rx_sym_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt_q;
   // Whole frames pass unchanged in length, so size limits hold end to end
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rxi_out <= '0;
         rx_sym_out <= '0;
         cnt_q <= 8'h00;
      end else begin
         rxi_out.valid <= txo_in.valid;
         rxi_out.last <= txo_in.last & txo_in.valid;
         if (txo_in.valid) begin
            // Flip one bit of a data octet, clear of type/length, for a bad frame
            rxi_out.data <= txo_in.data ^ {7'h00, corrupt_in && cnt_q == 8'h24};
         end else begin
            rxi_out.data <= ~rxi_out.data;
         end
         cnt_q <= corrupt_in ? cnt_q + {7'h00, txo_in.valid} : 8'h00;
         rx_sym_out.valid <= tx_sym_in.valid;
         rx_sym_out.sym <= tx_sym_in.valid ? tx_sym_in.sym : ~rx_sym_out.sym;
      end
   end
endmodule

// ### tb/mfe_top_tb.sv
// Purpose: Self-checking bench for frame encapsulation through a loopback physical layer.
// Assumes: octet enables every second cycle, which suits both plain and symbol modes.
// Notes: expected octets and check values are rebuilt here bit by bit.
`include "mfe_defs.svh"
module mfe_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic sym_mode = 1'b0;
   logic pad_dis = 1'b0;
   logic octet_en = 1'b0;
   logic corrupt = 1'b0;
   logic feed = 1'b0;
   mfe_pkg::mfe_octet_t tx_in = '0;
   mfe_pkg::mfe_octet_t txo_out, rxi, rx_out;
   mfe_pkg::mfe_sym_t tx_sym_out, rx_sym;
   logic tx_ready_out, rx_done_out, rx_crc_err_out, rx_size_err_out, rx_is_type_out;
   logic [15:0] rx_tl_out;
   logic [7:0] body[$], txq[$], rxq[$];
   logic [4:0] symq[$];
   logic done_seen, st_crc, st_size, st_type, st_last;
   logic [15:0] st_tl;
   int idx, tx_last_at, cyc = 0, n_mismatch = 0, n_compared = 0;

   always #25 clk_in = ~clk_in;

   mfe_top mfe_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .sym_mode_in(sym_mode),
      .pad_dis_in(pad_dis), .octet_en_in(octet_en), .tx_in(tx_in),
      .tx_ready_out(tx_ready_out), .txo_out(txo_out), .tx_sym_out(tx_sym_out),
      .rxi_in(rxi), .rx_sym_in(rx_sym), .rx_out(rx_out), .rx_done_out(rx_done_out),
      .rx_crc_err_out(rx_crc_err_out), .rx_size_err_out(rx_size_err_out),
      .rx_is_type_out(rx_is_type_out), .rx_tl_out(rx_tl_out));

   mfe_phy_model mfe_phy_model_inst (.clk_in(clk_in), .rstn_in(rstn_in),
      .corrupt_in(corrupt), .txo_in(txo_out), .tx_sym_in(tx_sym_out),
      .rxi_out(rxi), .rx_sym_out(rx_sym));

   // Host side: hold each octet until the consumed pulse, then move on
   always @(negedge clk_in) begin
      if (feed) begin
         octet_en = ~octet_en;
         if (tx_ready_out === 1'b1) idx++;
         tx_in.valid = idx < body.size();
         tx_in.data = tx_in.valid ? body[idx] : ~idx[7:0];
         tx_in.last = idx == body.size() - 1;
      end else begin
         octet_en = 1'b0;
         tx_in = '0;
      end
      if (txo_out.valid === 1'b1) begin
         if (txo_out.last === 1'b1) tx_last_at = txq.size();
         txq.push_back(txo_out.data);
      end
      if (tx_sym_out.valid === 1'b1) symq.push_back(tx_sym_out.sym);
      if (rx_out.valid === 1'b1) rxq.push_back(rx_out.data);
      if (rx_done_out === 1'b1) begin
         done_seen = 1'b1;
         st_crc = rx_crc_err_out;
         st_size = rx_size_err_out;
         st_type = rx_is_type_out;
         st_tl = rx_tl_out;
         st_last = rx_out.last;
      end
   end

   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Line order is bit 0 first, so the register shifts one input bit at a time
   function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
      logic [31:0] c;
      logic fb;
      c = 32'hffffffff;
      foreach (q[i]) begin
         for (int b = 0; b < 8; b++) begin
            fb = c[31] ^ q[i][b];
            c = {c[30:0], 1'b0};
            if (fb) c = c ^ 32'h04c11db7;
         end
      end
      return c;
   endfunction

   task automatic run_frame(input int nd, input logic [15:0] tl, input logic pd,
      input logic sm, input logic cor);
      logic [7:0] exp[$];
      logic [7:0] o;
      logic [31:0] c;
      int n;
      body = {};
      for (int i = 0; i < 6; i++) body.push_back(8'hff);
      for (int i = 0; i < 6; i++) body.push_back(i == 0 ? 8'h02 : 8'(i));
      body.push_back(tl[15:8]);
      body.push_back(tl[7:0]);
      // Data deliberately includes the preamble pattern, and the delimiter pattern once nd exceeds 128
      for (int i = 0; i < nd; i++) body.push_back(8'(i * 43 + 85));
      exp = body;
      if (!pd) while (exp.size() < 60) exp.push_back(8'h00);
      c = crc_of(exp);
      for (int j = 0; j < 4; j++) begin
         for (int b = 0; b < 8; b++) o[b] = ~c[31 - 8 * j - b];
         exp.push_back(o);
      end
      txq = {};
      symq = {};
      rxq = {};
      done_seen = 1'b0;
      tx_last_at = -1;
      pad_dis = pd;
      sym_mode = sm;
      corrupt = cor;
      idx = 0;
      @(negedge clk_in);
      feed = 1'b1;
      n = 0;
      while (!done_seen && n < 4000) begin
         @(negedge clk_in);
         n++;
      end
      repeat (8) @(negedge clk_in);
      feed = 1'b0;
      check(32'(done_seen), 32'h1);
      check(32'(txq.size()), 32'(exp.size() + 8));
      check(32'(tx_last_at), 32'(exp.size() + 7));
      for (int i = 0; i < 8 && i < txq.size(); i++) begin
         check(32'(txq[i]), i < 7 ? 32'h55 : 32'hd5);
      end
      for (int i = 0; i < exp.size() && i + 8 < txq.size(); i++) begin
         check(32'(txq[i + 8]), 32'(exp[i]));
      end
      if (!cor) begin
         check(32'(rxq.size()), 32'(exp.size()));
         for (int i = 0; i < exp.size() && i < rxq.size(); i++) begin
            check(32'(rxq[i]), 32'(exp[i]));
         end
      end
      check(32'(st_last), 32'h1);
      check(32'(st_crc), 32'(cor));
      check(32'(st_size), 32'(exp.size() < 64 || exp.size() > 1518));
      check(32'(st_type), 32'(tl > 16'h05dc));
      check(32'(st_tl), 32'(tl));
      if (sm) begin
         check(32'(symq.size()), 32'(2 * (exp.size() + 8) + 2));
         if (symq.size() > 3) begin
            check(32'({symq[0], symq[1]}), 32'({`MFE_SYM_J, `MFE_SYM_K}));
            n = symq.size();
            check(32'({symq[n - 2], symq[n - 1]}), 32'({`MFE_SYM_T, `MFE_SYM_R}));
         end
      end
   endtask

   task automatic t_pad_length();
      run_frame(20, 16'h0014, 1'b0, 1'b0, 1'b0);
      $display("test pad_length done");
   endtask

   task automatic t_nopad_type();
      run_frame(10, 16'h05dd, 1'b1, 1'b0, 1'b0);
      $display("test nopad_type done");
   endtask

   task automatic t_bad_crc();
      run_frame(46, 16'h05dc, 1'b0, 1'b0, 1'b1);
      $display("test bad_crc done");
   endtask

   task automatic t_symbol();
      run_frame(50, 16'h0800, 1'b0, 1'b1, 1'b0);
      $display("test symbol done");
   endtask

   task automatic t_max_frame();
      run_frame(1500, 16'hffff, 1'b0, 1'b0, 1'b0);
      $display("test max_frame done");
   endtask

   initial begin
      repeat (6) @(negedge clk_in);
      rstn_in = 1'b1;
      t_pad_length();
      t_nopad_type();
      t_bad_crc();
      t_symbol();
      t_max_frame();
      report_and_stop();
   end
endmodule
